// ==== shared/mgmt_ch1_pkg.sv ====
`default_nettype none
package mgmt_ch1_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] ADDR_ACCESS_CMD = 4'h0;
	localparam logic [3:0] ADDR_LINK_SEL   = 4'h1;
	localparam logic [3:0] ADDR_LINK_STAT  = 4'h2;
	// Access command field positions
	localparam int LAUNCH_BIT = 31;
	localparam int DIR_BIT    = 30;
	localparam int ACK_BIT    = 29;
	localparam int REG_LSB    = 21;
	localparam int PHY_LSB    = 16;
	// Link monitor select field positions
	localparam int LSRC_BIT   = 7;
	localparam int LIRQ_BIT   = 6;
	localparam int MON_LSB    = 0;
	// Reset values
	localparam logic [31:0] ACCESS_CMD_RST = 32'h0000_0000;
	localparam logic [31:0] LINK_SEL_RST   = 32'h0000_0000;
	// Management clock: mclk divided, half period in cycles
	localparam int MDC_HALF_DIV = 40;
	// Frame: 32 preamble, 2 start, 2 op, 5 phy, 5 reg, 2 turnaround, 16 data
	localparam int FRAME_BITS = 64;
	localparam int TA_BIT     = 46;
	localparam logic [4:0] LINK_STATUS_REG = 5'h01;
	localparam int LINK_STATUS_BIT = 2;

	typedef struct packed {
		logic        launch;
		logic        dir_write;
		logic        ack;
		logic [4:0]  reg_num;
		logic [4:0]  phy_num;
		logic [15:0] data;
	} access_cmd_t;

	typedef struct packed {
		logic       link_source_select;
		logic       link_change_irq_enable;
		logic [4:0] monitored_phy_number;
	} link_sel_t;
endpackage : mgmt_ch1_pkg
`default_nettype wire

// ==== logic/phy_mgmt_user_channel_one.sv ====
`timescale 1ns/100ps
`default_nettype none

module phy_mgmt_user_channel_one (
	input  wire logic        mclk,         // 200 MHz clock
	input  wire logic        rst_n,        // Synchronous reset, active low
	input  wire logic        sm_enable,    // Management machine enabled
	input  wire logic [3:0]  reg_addr,     // Register index
	input  wire logic [31:0] reg_wdata,    // Write data
	input  wire logic        reg_wr,       // Write strobe
	input  wire logic        reg_rd,       // Read strobe
	output logic      [31:0] reg_rdata,    // Read data, cycle after strobe
	output logic             mdc,          // Management clock
	output logic             mdio_o,       // Management data out
	output logic             mdio_oe_n,    // Low while driving data
	input  wire logic        mdio_i,       // Management data in
	output logic             link_change,  // One-cycle link change event
	output logic             link_up       // Recorded link state
);
	typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DONE} mstate_t;

	mgmt_ch1_pkg::access_cmd_t cmd_r;
	mgmt_ch1_pkg::link_sel_t   sel_r;
	mstate_t                   state_r;
	logic [6:0]                div_r;
	logic                      mdc_rise;
	logic                      mdc_fall;
	logic [6:0]                bit_r;
	logic [63:0]               shift_r;
	logic                      is_poll_r;
	logic                      is_write_r;
	logic [15:0]               rd_data_r;
	logic                      ack_r;
	logic                      frame_done;
	logic                      poll_pending_r;
	logic                      cmd_wr_ok;
	logic [15:0]               frame_cyc_r;

	assign cmd_wr_ok = reg_wr && (reg_addr == mgmt_ch1_pkg::ADDR_ACCESS_CMD) && !cmd_r.launch;

	// Management clock divider, enable pulses on each edge
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			div_r <= 7'h00;
			mdc   <= 1'b0;
		end else if (div_r == 7'(mgmt_ch1_pkg::MDC_HALF_DIV - 1)) begin
			div_r <= 7'h00;
			mdc   <= ~mdc;
		end else begin
			div_r <= div_r + 7'h01;
		end
	end
	assign mdc_rise = (div_r == 7'(mgmt_ch1_pkg::MDC_HALF_DIV - 1)) && !mdc;
	assign mdc_fall = (div_r == 7'(mgmt_ch1_pkg::MDC_HALF_DIV - 1)) && mdc;

	// Command register: software fields and hardware completion
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cmd_r <= mgmt_ch1_pkg::access_cmd_t'(mgmt_ch1_pkg::ACCESS_CMD_RST);
		end else if (frame_done && !is_poll_r) begin
			cmd_r.launch <= 1'b0;
			cmd_r.ack    <= !is_write_r && ack_r;
			if (!is_write_r) begin
				cmd_r.data <= rd_data_r;
			end
		end else if (cmd_wr_ok) begin
			cmd_r.dir_write <= reg_wdata[mgmt_ch1_pkg::DIR_BIT];
			cmd_r.ack       <= reg_wdata[mgmt_ch1_pkg::ACK_BIT];
			cmd_r.reg_num   <= reg_wdata[mgmt_ch1_pkg::REG_LSB +: 5];
			cmd_r.phy_num   <= reg_wdata[mgmt_ch1_pkg::PHY_LSB +: 5];
			cmd_r.data      <= reg_wdata[15:0];
			if (reg_wdata[mgmt_ch1_pkg::LAUNCH_BIT] && sm_enable) begin
				cmd_r.launch <= 1'b1;
			end
		end
	end

	// Link monitor select register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sel_r <= mgmt_ch1_pkg::link_sel_t'(7'(mgmt_ch1_pkg::LINK_SEL_RST));
		end else if (reg_wr && reg_addr == mgmt_ch1_pkg::ADDR_LINK_SEL) begin
			sel_r.link_source_select     <= reg_wdata[mgmt_ch1_pkg::LSRC_BIT];
			sel_r.link_change_irq_enable <= reg_wdata[mgmt_ch1_pkg::LIRQ_BIT];
			sel_r.monitored_phy_number   <= reg_wdata[mgmt_ch1_pkg::MON_LSB +: 5];
		end
	end

	// Read port, data one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			if (reg_addr == mgmt_ch1_pkg::ADDR_ACCESS_CMD) begin
				reg_rdata <= {cmd_r.launch, cmd_r.dir_write, cmd_r.ack, 3'h0,
					cmd_r.reg_num, cmd_r.phy_num, cmd_r.data};
			end else if (reg_addr == mgmt_ch1_pkg::ADDR_LINK_SEL) begin
				reg_rdata <= {24'h00_0000, sel_r.link_source_select,
					sel_r.link_change_irq_enable, 1'b0, sel_r.monitored_phy_number};
			end else if (reg_addr == mgmt_ch1_pkg::ADDR_LINK_STAT) begin
				reg_rdata <= {31'h0000_0000, link_up};
			end else begin
				reg_rdata <= 32'h0000_0000;
			end
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Poll request: a link poll is queued whenever the machine is idle and enabled with no access launched
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			poll_pending_r <= 1'b0;
		end else if (state_r == ST_IDLE && sm_enable && !cmd_r.launch) begin
			poll_pending_r <= 1'b1;
		end else if (state_r == ST_FRAME) begin
			poll_pending_r <= 1'b0;
		end
	end

	// Frame sequencer: bits change after the management clock falls
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r    <= ST_IDLE;
			bit_r      <= 7'h00;
			shift_r    <= 64'h0;
			is_poll_r  <= 1'b0;
			is_write_r <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (mdc_fall && cmd_r.launch) begin
						state_r    <= ST_FRAME;
						bit_r      <= 7'h00;
						is_poll_r  <= 1'b0;
						is_write_r <= cmd_r.dir_write;
						shift_r    <= {32'hffff_ffff, 2'b01,
							cmd_r.dir_write ? 2'b01 : 2'b10,
							cmd_r.phy_num, cmd_r.reg_num,
							cmd_r.dir_write ? 2'b10 : 2'b11,
							cmd_r.dir_write ? cmd_r.data : 16'hffff};
					end else if (mdc_fall && poll_pending_r && sm_enable) begin
						state_r    <= ST_FRAME;
						bit_r      <= 7'h00;
						is_poll_r  <= 1'b1;
						is_write_r <= 1'b0;
						shift_r    <= {32'hffff_ffff, 2'b01, 2'b10,
							sel_r.monitored_phy_number,
							mgmt_ch1_pkg::LINK_STATUS_REG, 2'b11, 16'hffff};
					end
				end
				ST_FRAME: begin
					if (mdc_fall) begin
						shift_r <= {shift_r[62:0], 1'b1};
						if (bit_r == 7'(mgmt_ch1_pkg::FRAME_BITS - 1)) begin
							state_r <= ST_DONE;
						end else begin
							bit_r <= bit_r + 7'h01;
						end
					end
				end
				ST_DONE: begin
					state_r <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end
	assign frame_done = (state_r == ST_DONE);

	// Pin drive: released during turnaround and data of a read
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mdio_o    <= 1'b1;
			mdio_oe_n <= 1'b1;
		end else if (state_r == ST_FRAME) begin
			mdio_o    <= shift_r[63];
			mdio_oe_n <= !is_write_r && (bit_r >= 7'(mgmt_ch1_pkg::TA_BIT));
		end else begin
			mdio_o    <= 1'b1;
			mdio_oe_n <= 1'b1;
		end
	end

	// Sample the PHY on rising management clock
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rd_data_r <= 16'h0000;
			ack_r     <= 1'b0;
		end else if (state_r == ST_IDLE) begin
			ack_r <= 1'b0;
		end else if (state_r == ST_FRAME && mdc_rise && !is_write_r) begin
			if (bit_r == 7'(mgmt_ch1_pkg::TA_BIT + 1)) begin
				ack_r <= !mdio_i;
			end else if (bit_r >= 7'(mgmt_ch1_pkg::TA_BIT + 2)) begin
				rd_data_r <= {rd_data_r[14:0], mdio_i};
			end
		end
	end

	// Link tracking and change event
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			link_up     <= 1'b0;
			link_change <= 1'b0;
		end else if (frame_done && is_poll_r && ack_r) begin
			link_up     <= rd_data_r[mgmt_ch1_pkg::LINK_STATUS_BIT];
			link_change <= sel_r.link_change_irq_enable &&
				(rd_data_r[mgmt_ch1_pkg::LINK_STATUS_BIT] != link_up);
		end else begin
			link_change <= 1'b0;
		end
	end

	// Frame length counter, watched by the checks below
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			frame_cyc_r <= 16'h0000;
		end else if (state_r == ST_FRAME) begin
			frame_cyc_r <= frame_cyc_r + 16'h0001;
		end else begin
			frame_cyc_r <= 16'h0000;
		end
	end

	// Checks
	AST_LAUNCH_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n)
		cmd_r.launch && state_r != ST_DONE |=> cmd_r.launch)
		else $error("launch cleared early");
	AST_DONE_CLEARS: assert property (@(posedge mclk) disable iff (!rst_n)
		frame_done && !is_poll_r |=> !cmd_r.launch)
		else $error("launch not cleared");
	AST_BLOCK_WR: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_wr && reg_addr == mgmt_ch1_pkg::ADDR_ACCESS_CMD && cmd_r.launch && !frame_done
		|=> $stable(cmd_r.data) && $stable(cmd_r.phy_num))
		else $error("command changed while busy");
	AST_DISABLED: assert property (@(posedge mclk) disable iff (!rst_n)
		!cmd_r.launch && !sm_enable |=> !cmd_r.launch)
		else $error("launch set while disabled");
	AST_ZERO_WR: assert property (@(posedge mclk) disable iff (!rst_n)
		cmd_wr_ok && !reg_wdata[mgmt_ch1_pkg::LAUNCH_BIT] |=> !cmd_r.launch)
		else $error("zero write launched");
	AST_SET: assert property (@(posedge mclk) disable iff (!rst_n)
		cmd_wr_ok && sm_enable && reg_wdata[mgmt_ch1_pkg::LAUNCH_BIT] |=> cmd_r.launch)
		else $error("launch not taken");
	AST_WRITE_DRIVES: assert property (@(posedge mclk) disable iff (!rst_n)
		state_r == ST_FRAME && is_write_r |=> mdio_oe_n == 1'b0 || state_r != ST_FRAME)
		else $error("write frame released pin");
	AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
		link_change |-> $past(sel_r.link_change_irq_enable))
		else $error("event while disabled");
	AST_CHANGE: assert property (@(posedge mclk) disable iff (!rst_n)
		link_change |-> link_up != $past(link_up))
		else $error("event without change");
	AST_SRC_ZERO: assert property (@(posedge mclk)
		!rst_n |=> !sel_r.link_source_select)
		else $error("select not reset");

	// Register port: idle zeros, reserved bits read as zero
	AST_RDATA_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside read cycle");
	AST_RSVD_CMD: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_rd && reg_addr == mgmt_ch1_pkg::ADDR_ACCESS_CMD |=> reg_rdata[28:26] == 3'h0)
		else $error("command reserved bits set");
	AST_RSVD_SEL: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_rd && reg_addr == mgmt_ch1_pkg::ADDR_LINK_SEL
		|=> reg_rdata[31:8] == 24'h00_0000 && !reg_rdata[5])
		else $error("select reserved bits set");
	AST_SEL_WR: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_wr && reg_addr == mgmt_ch1_pkg::ADDR_LINK_SEL
		|=> sel_r.monitored_phy_number == $past(reg_wdata[mgmt_ch1_pkg::MON_LSB +: 5]))
		else $error("monitored number not written");

	// Completion of a software access
	AST_ACK_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
		frame_done && !is_poll_r && is_write_r |=> !cmd_r.ack)
		else $error("acknowledge left after write");
	AST_READ_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
		frame_done && !is_poll_r && !is_write_r |=> cmd_r.data == $past(rd_data_r))
		else $error("read data not loaded");
	AST_FRAME_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
		frame_done |-> frame_cyc_r == 16'(mgmt_ch1_pkg::FRAME_BITS * 2 * mgmt_ch1_pkg::MDC_HALF_DIV))
		else $error("frame length wrong");

	// Frame start and header contents
	AST_START_CMD: assert property (@(posedge mclk) disable iff (!rst_n)
		state_r == ST_IDLE && mdc_fall && cmd_r.launch |=> state_r == ST_FRAME && !is_poll_r)
		else $error("pending access not started");
	AST_HDR_FIELDS: assert property (@(posedge mclk) disable iff (!rst_n)
		state_r == ST_IDLE && mdc_fall && cmd_r.launch
		|=> shift_r[27:23] == $past(cmd_r.phy_num) && shift_r[22:18] == $past(cmd_r.reg_num))
		else $error("header fields wrong");
	AST_OP_CODE: assert property (@(posedge mclk) disable iff (!rst_n)
		state_r == ST_IDLE && mdc_fall && cmd_r.launch
		|=> shift_r[29:28] == ($past(cmd_r.dir_write) ? 2'b01 : 2'b10))
		else $error("operation code wrong");
	AST_POLL_ADDR: assert property (@(posedge mclk) disable iff (!rst_n)
		state_r == ST_IDLE && mdc_fall && !cmd_r.launch && poll_pending_r && sm_enable
		|=> shift_r[27:23] == $past(sel_r.monitored_phy_number)
		&& shift_r[22:18] == mgmt_ch1_pkg::LINK_STATUS_REG)
		else $error("poll addressed wrong PHY");

	// Pin behaviour and management clock
	AST_IDLE_PIN: assert property (@(posedge mclk) disable iff (!rst_n)
		state_r != ST_FRAME |=> mdio_oe_n && mdio_o)
		else $error("pin driven outside frame");
	AST_READ_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
		state_r == ST_FRAME && !is_write_r && bit_r >= 7'(mgmt_ch1_pkg::TA_BIT) |=> mdio_oe_n)
		else $error("pin driven during read turnaround");
	AST_BIT_RANGE: assert property (@(posedge mclk) disable iff (!rst_n)
		state_r == ST_FRAME |-> bit_r < 7'(mgmt_ch1_pkg::FRAME_BITS))
		else $error("bit counter out of range");
	AST_MDC_RATE: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(mdc) |-> $past(div_r) == 7'(mgmt_ch1_pkg::MDC_HALF_DIV - 1))
		else $error("management clock edge off rate");

	// Link tracking
	AST_LINK_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
		!(frame_done && is_poll_r && ack_r) |=> $stable(link_up))
		else $error("link state moved without poll");
	AST_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
		link_change |=> !link_change)
		else $error("link event longer than one cycle");
	COV_WRITE: cover property (@(posedge mclk) disable iff (!rst_n) frame_done && is_write_r);
	COV_READ: cover property (@(posedge mclk) disable iff (!rst_n) frame_done && !is_poll_r && ack_r);
	COV_LINK: cover property (@(posedge mclk) disable iff (!rst_n) link_change);
	COV_REFUSED: cover property (@(posedge mclk) disable iff (!rst_n)
		reg_wr && reg_addr == mgmt_ch1_pkg::ADDR_ACCESS_CMD && cmd_r.launch);
	COV_NO_ACK: cover property (@(posedge mclk) disable iff (!rst_n)
		frame_done && !is_poll_r && !is_write_r && !ack_r);
endmodule : phy_mgmt_user_channel_one
`default_nettype wire

// ==== verif/mdio_phy_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Behavioural PHY on the management bus; answers reads addressed to my_addr
module mdio_phy_model (
	input  wire logic        mdc,        // Management clock from the block
	input  wire logic        mdio,       // Resolved data line
	input  wire logic [4:0]  my_addr,    // This PHY's address
	input  wire logic        link_in,    // Link state reported in reg 1 bit 2
	output logic             phy_o,      // Data driven by the PHY
	output logic             phy_oe,     // High while the PHY drives
	output logic      [12:0] last_hdr    // Start bit, op, phy, reg of last frame
);
	logic [15:0] regs [32];
	logic [12:0] hdr;
	logic [15:0] sh;
	logic [15:0] rv;
	int          cnt;
	wire logic   rd_hit = (hdr[11:10] == 2'b10) && (hdr[9:5] == my_addr);

	initial begin
		cnt = 0;
		phy_o = 1'b1;
		phy_oe = 1'b0;
		last_hdr = '0;
		hdr = '0;
		for (int i = 0; i < 32; i++) regs[i] = 16'h0000;
	end

	// Frame decoder: first zero after the idle ones is the start bit
	always @(posedge mdc) begin
		if (cnt == 0) begin
			if (mdio === 1'b0) cnt = 1;
		end else begin
			cnt = cnt + 1;
			if (cnt <= 14) hdr = {hdr[11:0], mdio};
			if (cnt >= 17) sh = {sh[14:0], mdio};
			if (cnt == 32) begin
				last_hdr = hdr;
				if (hdr[11:10] == 2'b01 && hdr[9:5] == my_addr) regs[hdr[4:0]] = sh;
				cnt = 0;
			end
		end
	end

	// Turnaround acknowledge and read data, MSB first, changed after mdc falls
	always @(negedge mdc) begin
		if (rd_hit && cnt >= 15 && cnt <= 31) begin
			phy_oe = 1'b1;
			if (cnt == 15) begin
				phy_o = 1'b0;
			end else begin
				if (cnt == 16) begin
					rv = regs[hdr[4:0]];
					if (hdr[4:0] == 5'h01) rv[2] = link_in;
				end
				phy_o = rv[31 - cnt];
			end
		end else begin
			phy_oe = 1'b0;
		end
	end
endmodule : mdio_phy_model
`default_nettype wire

// ==== verif/phy_mgmt_user_channel_one_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_user_channel_one_tb;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sm_enable = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        mdc, mdio_o, mdio_oe_n, phy_o, phy_oe, link_change, link_up;
	logic        link_in = 1'b0;
	logic [12:0] last_hdr;
	logic [31:0] v;
	int          errors = 0;
	int          n_checks = 0;
	int          n_evt = 0;
	// Pulled-up shared data line
	wire logic   mdio_line = !mdio_oe_n ? mdio_o : (phy_oe ? phy_o : 1'b1);

	always #2.5 mclk = ~mclk;

	phy_mgmt_user_channel_one i_phy_mgmt_user_channel_one (.mclk(mclk), .rst_n(rst_n),
		.sm_enable(sm_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mdc(mdc), .mdio_o(mdio_o),
		.mdio_oe_n(mdio_oe_n), .mdio_i(mdio_line), .link_change(link_change), .link_up(link_up));
	mdio_phy_model i_mdio_phy_model (.mdc(mdc), .mdio(mdio_line), .my_addr(5'h03),
		.link_in(link_in), .phy_o(phy_o), .phy_oe(phy_oe), .last_hdr(last_hdr));

	// Count link change events
	always @(posedge mclk) if (link_change === 1'b1) n_evt <= n_evt + 1;

	function automatic logic [31:0] cmd(logic l, logic w, logic a, logic [4:0] rg,
		logic [4:0] ph, logic [15:0] d);
		return {l, w, a, 3'h0, rg, ph, d};
	endfunction : cmd

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask : rd

	// Poll the command register until launch clears, bounded
	task automatic wait_done();
		for (int i = 0; i < 8000; i++) begin
			rd(mgmt_ch1_pkg::ADDR_ACCESS_CMD, v);
			if (v[31] === 1'b0) return;
		end
		check(32'h1, 32'h0);
	endtask : wait_done

	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up

	// Watchdog
	initial begin
		repeat (80000) @(posedge mclk);
		errors++;
		wrap_up();
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		rd(mgmt_ch1_pkg::ADDR_ACCESS_CMD, v); check(v, 32'h0000_0000);
		rd(mgmt_ch1_pkg::ADDR_LINK_SEL, v); check(v, 32'h0000_0000);
		rd(4'hf, v); check(v, 32'h0000_0000);
		wr(mgmt_ch1_pkg::ADDR_LINK_SEL, 32'h0000_0003);
		// Launch refused while the machine is disabled, reserved bits stay zero
		wr(mgmt_ch1_pkg::ADDR_ACCESS_CMD, 32'hdc00_0000 | cmd(1, 1, 0, 5'h0a, 5'h03, 16'h1234));
		rd(mgmt_ch1_pkg::ADDR_ACCESS_CMD, v); check(v, cmd(0, 1, 0, 5'h0a, 5'h03, 16'h1234));
		@(posedge mclk);
		sm_enable <= 1'b1;
		// Write frame, with a blocked overwrite while pending
		wr(mgmt_ch1_pkg::ADDR_ACCESS_CMD, cmd(1, 1, 0, 5'h0a, 5'h03, 16'ha55a));
		rd(mgmt_ch1_pkg::ADDR_ACCESS_CMD, v); check(v, cmd(1, 1, 0, 5'h0a, 5'h03, 16'ha55a));
		wr(mgmt_ch1_pkg::ADDR_ACCESS_CMD, cmd(0, 0, 0, 5'h1f, 5'h1f, 16'h0000));
		rd(mgmt_ch1_pkg::ADDR_ACCESS_CMD, v); check(v, cmd(1, 1, 0, 5'h0a, 5'h03, 16'ha55a));
		wait_done();
		check({19'h0, last_hdr}, {19'h0, 1'b1, 2'b01, 5'h03, 5'h0a});
		check({16'h0, i_mdio_phy_model.regs[5'h0a]}, 32'h0000_a55a);
		check(v, cmd(0, 1, 0, 5'h0a, 5'h03, 16'ha55a));
		// Read frame from the present PHY
		i_mdio_phy_model.regs[5'h11] = 16'hbeef;
		wr(mgmt_ch1_pkg::ADDR_ACCESS_CMD, cmd(1, 0, 0, 5'h11, 5'h03, 16'h0000));
		wait_done();
		check(v, cmd(0, 0, 1, 5'h11, 5'h03, 16'hbeef));
		// Read frame to an absent PHY: stale acknowledge cleared, pulled-up data
		wr(mgmt_ch1_pkg::ADDR_ACCESS_CMD, cmd(1, 0, 1, 5'h11, 5'h1e, 16'h0000));
		wait_done();
		check(v, cmd(0, 0, 0, 5'h11, 5'h1e, 16'hffff));
		// Link change with events enabled on the monitored PHY
		wr(mgmt_ch1_pkg::ADDR_LINK_SEL, 32'h0000_0043);
		rd(mgmt_ch1_pkg::ADDR_LINK_SEL, v); check(v, 32'h0000_0043);
		n_evt = 0;
		link_in = 1'b1;
		for (int i = 0; i < 14000 && n_evt == 0; i++) @(posedge mclk);
		@(negedge mclk);
		check(n_evt, 1);
		check({31'h0, link_up}, 32'h1);
		rd(mgmt_ch1_pkg::ADDR_LINK_STAT, v); check({31'h0, v[0]}, 32'h1);
		// Link change with events disabled
		wr(mgmt_ch1_pkg::ADDR_LINK_SEL, 32'h0000_0003);
		link_in = 1'b0;
		repeat (12000) @(posedge mclk);
		check(n_evt, 1);
		check({31'h0, link_up}, 32'h0);
		wrap_up();
	end
endmodule : phy_mgmt_user_channel_one_tb
`default_nettype wire
